// *** rtl/eil_pkg.sv ***
package eil_pkg;
   // Register byte addresses on the AXI4-Lite slave
   localparam logic [3:0] EIL_ADDR_SCR = 4'h0;
   localparam logic [3:0] EIL_ADDR_BRK = 4'h4;
   localparam logic [3:0] EIL_ADDR_PIN = 4'h8;
   // Field positions in the status and control register
   localparam int EIL_BIT_MODE = 0;
   localparam int EIL_BIT_MASK = 1;
   localparam int EIL_BIT_ACK = 2;
   localparam int EIL_BIT_PEND = 3;
   // Field positions in the break control register
   localparam int EIL_BIT_BRKCLR = 0;
   localparam int EIL_BIT_BRK = 1;
   // Reset values
   localparam logic EIL_RST_MODE = 1'b0;
   localparam logic EIL_RST_MASK = 1'b0;
   localparam logic EIL_RST_BRKCLR = 1'b0;
   // Interrupt vector locations
   localparam logic [15:0] EIL_VEC_HI = 16'hfffa;
   localparam logic [15:0] EIL_VEC_LO = 16'hfffb;
   localparam logic [1:0] EIL_RESP_OKAY = 2'h0;
   localparam logic [1:0] EIL_RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic pending;
      logic ack;
      logic mask;
      logic mode;
   } eil_scr_t;

   typedef enum logic [2:0] {
      EIL_RD_IDLE = 3'b001,
      EIL_RD_RESP = 3'b010,
      EIL_RD_HOLD = 3'b100
   } eil_rd_state_t;
endpackage

// *** rtl/external_interrupt_latch.sv ***
// Our own choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ns
module external_interrupt_latch
   import eil_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic irqPin_n,
   input wire logic vectorFetch,
   input wire logic breakState,
   output logic irqRequest,
   output logic pinLevel,
   output logic [15:0] vectorAddrHi,
   output logic [15:0] vectorAddrLo,
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);

   logic pinMeta;
   logic pinSync;
   logic pinPrev;
   logic fallEdge;
   logic latch;
   eil_scr_t scr;
   logic breakClearEnable;
   logic levelSel;
   logic requestMask;
   logic ackSeen;
   logic [2:0] primed;
   logic next_awHeld;
   logic next_wHeld;
   logic next_bvalid;
   logic awHeld;
   logic wHeld;
   logic [3:0] awAddr;
   logic [31:0] wData;
   logic [3:0] wStrb;
   logic wrFire;
   logic ackWrite;
   logic ackEffective;
   logic clearReq;
   logic [3:0] arAddr;
   eil_rd_state_t rdState;

   // Two-stage synchroniser; only pinSync and later stages are used in logic
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pinMeta <= 1'b1;
         pinSync <= 1'b1;
         pinPrev <= 1'b1;
      end else begin
         pinMeta <= irqPin_n;
         pinSync <= pinMeta;
         pinPrev <= pinSync;
      end
   end

   // The stages reset high, so a pin held low through reset would look like a
   // fresh edge; edges count only once every stage holds a real sample
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         primed <= 3'h0;
      end else begin
         primed <= {primed[1:0], 1'b1};
      end
   end

   assign fallEdge = primed[2] & pinPrev & ~pinSync;

   // Shared by the write response and the read response
   function automatic logic addrKnown(input logic [3:0] addr);
      return addr == EIL_ADDR_SCR || addr == EIL_ADDR_BRK || addr == EIL_ADDR_PIN;
   endfunction

   // Write channel: address and data taken in either order, one at a time
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         awHeld <= 1'b0;
         wHeld <= 1'b0;
         awAddr <= 4'h0;
         wData <= 32'h0;
         wStrb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= EIL_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld <= 1'b1;
            awAddr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld <= 1'b1;
            wData <= s_axi_wdata;
            wStrb <= s_axi_wstrb;
         end
         if (wrFire) begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= addrKnown(awAddr) ? EIL_RESP_OKAY : EIL_RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Ready leaves a flop, so it is worked out from the holding state after this edge
   always_comb begin
      next_awHeld = awHeld;
      next_wHeld = wHeld;
      next_bvalid = s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
         next_awHeld = 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_wHeld = 1'b1;
      end
      if (wrFire) begin
         next_awHeld = 1'b0;
         next_wHeld = 1'b0;
         next_bvalid = 1'b1;
      end else if (s_axi_bvalid && s_axi_bready) begin
         next_bvalid = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
      end else begin
         s_axi_awready <= ~next_awHeld & ~next_bvalid;
         s_axi_wready <= ~next_wHeld & ~next_bvalid;
      end
   end
   assign wrFire = awHeld & wHeld & ~s_axi_bvalid;
   assign ackWrite = wrFire && awAddr == EIL_ADDR_SCR && wStrb[0] && wData[EIL_BIT_ACK];
   // Break protection: in break state, acknowledge writes only count when clearing is enabled
   assign ackEffective = ackWrite & (~breakState | breakClearEnable);

   // Control bits
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         levelSel <= EIL_RST_MODE;
         requestMask <= EIL_RST_MASK;
         breakClearEnable <= EIL_RST_BRKCLR;
      end else if (wrFire && wStrb[0]) begin
         if (awAddr == EIL_ADDR_SCR) begin
            levelSel <= wData[EIL_BIT_MODE];
            requestMask <= wData[EIL_BIT_MASK];
         end
         if (awAddr == EIL_ADDR_BRK) begin
            breakClearEnable <= wData[EIL_BIT_BRKCLR];
         end
      end
   end

   // Acknowledge is never stored, so it always reads back as zero
   assign scr = {latch, 1'b0, requestMask, levelSel};

   // Acknowledge from the CPU fetch or software; in level mode the low pin keeps it
   assign clearReq = vectorFetch | ackEffective;

   // Level mode: an acknowledge taken while the pin is still low is kept here and
   // applied once the pin is back high, so either order clears the request
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ackSeen <= 1'b0;
      end else if (!scr.mode || pinSync) begin
         ackSeen <= 1'b0;
      end else if (clearReq && latch) begin
         ackSeen <= 1'b1;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         latch <= 1'b0;
      end else if (fallEdge) begin
         latch <= 1'b1;
      end else if (scr.mode && !pinSync) begin
         latch <= 1'b1;
      end else if (clearReq || ackSeen) begin
         latch <= 1'b0;
      end
   end

   // Outputs toward CPU and priority logic
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         irqRequest <= 1'b0;
         pinLevel <= 1'b1;
         vectorAddrHi <= EIL_VEC_HI;
         vectorAddrLo <= EIL_VEC_LO;
      end else begin
         irqRequest <= latch & ~scr.mask;
         pinLevel <= pinSync;
         vectorAddrHi <= EIL_VEC_HI;
         vectorAddrLo <= EIL_VEC_LO;
      end
   end

   // Read channel
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rdState <= EIL_RD_IDLE;
         arAddr <= 4'h0;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= EIL_RESP_OKAY;
      end else begin
         case (rdState)
            EIL_RD_IDLE: begin
               s_axi_arready <= 1'b1;
               if (s_axi_arvalid && s_axi_arready) begin
                  arAddr <= s_axi_araddr;
                  s_axi_arready <= 1'b0;
                  rdState <= EIL_RD_RESP;
               end
            end
            EIL_RD_RESP: begin
               s_axi_rvalid <= 1'b1;
               s_axi_rresp <= addrKnown(arAddr) ? EIL_RESP_OKAY : EIL_RESP_SLVERR;
               case (arAddr)
                  EIL_ADDR_SCR: s_axi_rdata <= {28'h0, scr};
                  EIL_ADDR_BRK: s_axi_rdata <= {30'h0, breakState, breakClearEnable};
                  EIL_ADDR_PIN: s_axi_rdata <= {31'h0, pinSync};
                  default: begin
                     s_axi_rdata <= 32'h0;
                     s_axi_rresp <= EIL_RESP_SLVERR;
                  end
               endcase
               rdState <= EIL_RD_HOLD;
            end
            EIL_RD_HOLD: begin
               if (s_axi_rready) begin
                  s_axi_rvalid <= 1'b0;
                  rdState <= EIL_RD_IDLE;
               end
            end
            default: rdState <= EIL_RD_IDLE;
         endcase
      end
   end

   property p_edge_sets;
      @(posedge clk) disable iff (!nrst) fallEdge |=> latch;
   endproperty
   a_edge_sets: assert property (p_edge_sets) else $error("edge did not set latch");

   property p_fetch_clears;
      @(posedge clk) disable iff (!nrst)
         vectorFetch && !fallEdge && !(scr.mode && !pinSync) |=> !latch;
   endproperty
   a_fetch_clears: assert property (p_fetch_clears) else $error("fetch left latch");

   property p_ack_clears;
      @(posedge clk) disable iff (!nrst)
         ackWrite && !breakState && !fallEdge && !(scr.mode && !pinSync) |=> !latch;
   endproperty
   a_ack_clears: assert property (p_ack_clears) else $error("ack left latch");

   property p_level_holds;
      @(posedge clk) disable iff (!nrst) scr.mode && !pinSync |=> latch;
   endproperty
   a_level_holds: assert property (p_level_holds) else $error("level lost");

   property p_mask_blocks;
      @(posedge clk) disable iff (!nrst) scr.mask |=> !irqRequest;
   endproperty
   a_mask_blocks: assert property (p_mask_blocks) else $error("masked request");

   property p_unmasked_passes;
      @(posedge clk) disable iff (!nrst) latch && !scr.mask |=> irqRequest;
   endproperty
   a_unmasked_passes: assert property (p_unmasked_passes) else $error("request lost");

   property p_break_protect;
      @(posedge clk) disable iff (!nrst)
         ackWrite && breakState && !breakClearEnable && !vectorFetch && latch |=> latch;
   endproperty
   a_break_protect: assert property (p_break_protect) else $error("break ack cleared");

   property p_break_clear;
      @(posedge clk) disable iff (!nrst)
         ackWrite && breakState && breakClearEnable && !fallEdge && !(scr.mode && !pinSync)
         |=> !latch;
   endproperty
   a_break_clear: assert property (p_break_clear) else $error("break ack ignored");

   sequence s_pin_fall;
      pinSync ##1 !pinSync;
   endsequence
   property p_pin_follow;
      @(posedge clk) disable iff (!nrst) s_pin_fall |=> !pinLevel;
   endproperty
   a_pin_follow: assert property (p_pin_follow) else $error("pin level stale");

   sequence s_ack_while_low;
      scr.mode && latch && !pinSync && clearReq;
   endsequence
   property p_ack_remembered;
      @(posedge clk) disable iff (!nrst) s_ack_while_low |=> ackSeen;
   endproperty
   a_ack_remembered: assert property (p_ack_remembered) else $error("early ack lost");

   property p_release_clears;
      @(posedge clk) disable iff (!nrst) ackSeen && pinSync |=> !latch;
   endproperty
   a_release_clears: assert property (p_release_clears) else $error("release kept latch");

   sequence s_scr_read;
      rdState == EIL_RD_RESP && arAddr == EIL_ADDR_SCR;
   endsequence
   property p_ack_reads_zero;
      @(posedge clk) disable iff (!nrst) s_scr_read |=> !s_axi_rdata[EIL_BIT_ACK];
   endproperty
   a_ack_reads_zero: assert property (p_ack_reads_zero) else $error("ack bit read back");

   property p_pend_shows_latch;
      @(posedge clk) disable iff (!nrst)
         s_scr_read |=> s_axi_rdata[EIL_BIT_PEND] == $past(latch);
   endproperty
   a_pend_shows_latch: assert property (p_pend_shows_latch) else $error("pending stale");

   sequence s_scr_write;
      wrFire && wStrb[0] && awAddr == EIL_ADDR_SCR;
   endsequence
   property p_mask_written;
      @(posedge clk) disable iff (!nrst)
         s_scr_write |=> scr.mask == $past(wData[EIL_BIT_MASK]);
   endproperty
   a_mask_written: assert property (p_mask_written) else $error("mask not written");

   property p_mode_written;
      @(posedge clk) disable iff (!nrst)
         s_scr_write |=> scr.mode == $past(wData[EIL_BIT_MODE]);
   endproperty
   a_mode_written: assert property (p_mode_written) else $error("mode not written");

   sequence s_ack_then_fall;
      ackEffective ##1 fallEdge;
   endsequence
   property p_edge_after_ack;
      @(posedge clk) disable iff (!nrst) s_ack_then_fall |=> latch;
   endproperty
   a_edge_after_ack: assert property (p_edge_after_ack) else $error("edge after ack lost");

endmodule // external_interrupt_latch

// *** verification/eil_irq_source.sv ***
`timescale 1ns/1ns
module eil_irq_source (
   input wire logic clk,
   input wire logic pullLow,
   output logic irqPin_n
);
   // Pull-up holds the line high whenever the source lets go
   initial irqPin_n = 1'b1;
   always @(posedge clk) begin
      irqPin_n <= ~pullLow;
   end
endmodule // eil_irq_source

// *** verification/test_external_interrupt_latch.sv ***
`timescale 1ns/1ns
module test_external_interrupt_latch
   import eil_pkg::*;
;
   logic clk, nrst, pullLow, irqPin_n, vectorFetch, breakState, irqRequest, pinLevel;
   logic [15:0] vecHi, vecLo;
   logic [3:0] awaddr, araddr, wstrb;
   logic [31:0] wdata, rdata, rd;
   logic [1:0] bresp, rresp, rr, br;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   int fails = 0;
   int n_checks = 0;
   int cyc = 0;
   typedef struct {logic [3:0] a; logic [31:0] d; logic [31:0] e; logic [1:0] r;} eil_row_t;
   eil_row_t rows[6] = '{'{EIL_ADDR_SCR, 32'h3, 32'h3, 2'h0}, '{EIL_ADDR_SCR, 32'h6, 32'h2, 2'h0},
      '{EIL_ADDR_SCR, 32'h0, 32'h0, 2'h0}, '{EIL_ADDR_BRK, 32'h1, 32'h1, 2'h0},
      '{EIL_ADDR_BRK, 32'h0, 32'h0, 2'h0}, '{4'hc, 32'h5, 32'h0, 2'h2}};

   eil_irq_source eil_irq_source_inst (.clk(clk), .pullLow(pullLow), .irqPin_n(irqPin_n));
   external_interrupt_latch external_interrupt_latch_inst (.clk(clk), .nrst(nrst),
      .irqPin_n(irqPin_n), .vectorFetch(vectorFetch), .breakState(breakState),
      .irqRequest(irqRequest), .pinLevel(pinLevel), .vectorAddrHi(vecHi), .vectorAddrLo(vecLo),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

   task chk(input string n, input logic [31:0] s, input logic [31:0] e);
      n_checks++;
      if (s !== e) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask

   task final_report;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // Handshakes are judged at the rising edge, on the values that stood before it
   task wr(input logic [3:0] a, input logic [31:0] d);
      logic aw, w;
      aw = 1'b0;
      w = 1'b0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (!(aw && w)) begin
         @(posedge clk);
         if (!aw && awready) begin
            aw = 1'b1;
            awvalid <= 1'b0;
         end
         if (!w && wready) begin
            w = 1'b1;
            wvalid <= 1'b0;
         end
      end
      bready <= 1'b1;
      @(posedge clk);
      while (!bvalid) begin
         @(posedge clk);
      end
      br = bresp;
      bready <= 1'b0;
   endtask

   task rdw(input logic [3:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      @(posedge clk);
      while (!arready) begin
         @(posedge clk);
      end
      arvalid <= 1'b0;
      rready <= 1'b1;
      @(posedge clk);
      while (!rvalid) begin
         @(posedge clk);
      end
      rd = rdata;
      rr = rresp;
      rready <= 1'b0;
   endtask

   // Fixed wait covers synchroniser plus latch and request stages
   task pin(input logic v);
      pullLow <= v;
      repeat (6) @(posedge clk);
   endtask

   task pend(input logic p, input logic q);
      rdw(EIL_ADDR_SCR);
      chk("pending", 32'(rd[EIL_BIT_PEND]), 32'(p));
      chk("irqRequest", 32'(irqRequest), 32'(q));
   endtask

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         fails++;
         final_report;
      end
   end

   initial begin
      {nrst, pullLow, vectorFetch, breakState, awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, araddr, wdata} = '0;
      wstrb = 4'hf;
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      rdw(EIL_ADDR_SCR);
      chk("scrReset", rd, 32'h0);
      rdw(EIL_ADDR_BRK);
      chk("brkReset", rd, 32'h0);
      chk("vecHi", 32'(vecHi), 32'hfffa);
      chk("vecLo", 32'(vecLo), 32'hfffb);
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         chk("wrResp", 32'(br), 32'(rows[i].r));
         rdw(rows[i].a);
         chk("regData", rd, rows[i].e);
         chk("regResp", 32'(rr), 32'(rows[i].r));
      end
      pin(1'b1);
      pend(1'b1, 1'b1);
      rdw(EIL_ADDR_PIN);
      chk("pinReg", 32'(rd[0]), 32'h0);
      chk("pinLevel", 32'(pinLevel), 32'h0);
      wr(EIL_ADDR_SCR, 32'h2);
      pend(1'b1, 1'b0);
      wr(EIL_ADDR_SCR, 32'h6);
      pend(1'b0, 1'b0);
      pin(1'b0);
      pin(1'b1);
      pend(1'b1, 1'b0);
      wr(EIL_ADDR_SCR, 32'h0);
      pend(1'b1, 1'b1);
      vectorFetch <= 1'b1;
      @(posedge clk);
      vectorFetch <= 1'b0;
      repeat (2) @(posedge clk);
      pend(1'b0, 1'b0);
      // Level mode, acknowledge first and release of the pin after it
      pin(1'b0);
      wr(EIL_ADDR_SCR, 32'h1);
      pin(1'b1);
      pend(1'b1, 1'b1);
      wr(EIL_ADDR_SCR, 32'h5);
      pend(1'b1, 1'b1);
      pin(1'b0);
      pend(1'b0, 1'b0);
      // Release of the pin first and acknowledge after it
      pin(1'b1);
      pin(1'b0);
      pend(1'b1, 1'b1);
      wr(EIL_ADDR_SCR, 32'h5);
      pend(1'b0, 1'b0);
      wr(EIL_ADDR_SCR, 32'h0);
      breakState <= 1'b1;
      pin(1'b1);
      wr(EIL_ADDR_SCR, 32'h4);
      pend(1'b1, 1'b1);
      wr(EIL_ADDR_BRK, 32'h1);
      rdw(EIL_ADDR_BRK);
      chk("brkState", rd, 32'h3);
      wr(EIL_ADDR_SCR, 32'h4);
      breakState <= 1'b0;
      pend(1'b0, 1'b0);
      wr(EIL_ADDR_BRK, 32'h0);
      // Reset in mid-run with the pin held low in level mode, masked as advised
      pin(1'b0);
      wr(EIL_ADDR_SCR, 32'h3);
      pin(1'b1);
      pend(1'b1, 1'b0);
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      chk("irqInReset", 32'(irqRequest), 32'h0);
      nrst <= 1'b1;
      @(posedge clk);
      rdw(EIL_ADDR_SCR);
      chk("modeAfterReset", 32'(rd[EIL_BIT_MODE]), 32'h0);
      chk("pendAfterReset", 32'(rd[EIL_BIT_PEND]), 32'h0);
      chk("maskAfterReset", 32'(rd[EIL_BIT_MASK]), 32'h0);
      pullLow <= 1'b0;
      final_report;
   end
endmodule // test_external_interrupt_latch
